// >>> usb_dma_regs.svh
// Register offsets, field positions, reset values and policy defaults
// Operation
// - Bits fifteen to nine reserved; write zeros
// - Status bit eight flags missed previous frame
// - Error disabled: missed packet acts zero-byte (code does this for OUT only; IN ignores it)
// - Error enabled: halt on rising missing flag
// - Short and join controls sampled at start/reload
// - IN, short off: no zero packet added
// - IN, short on: zero packet via count clear
// - OUT, short off: full last packet ends
// - OUT, short on: await zero packet, discard else
// - IN, join off: partial packet sent short
// - IN, join on: partial packet held for next
// - OUT, join off: excess bytes set overflow
// - OUT, join on: record position, continue later
// - Start bit launches; cleared at transfer end
// - Reload swaps addresses, starts new transfer
// - Overflow flag set by hardware, write-one-clear
`ifndef USB_DMA_REGS_SVH
`define USB_DMA_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define DMA_CTL_OFFSET   4'h0
`define DMA_CTL_RESET    16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DMA_GO_BIT       0
`define DMA_STP_BIT      1
`define DMA_RLD_BIT      2
`define DMA_OVF_BIT      3
`define DMA_END_BIT      4
`define DMA_CAT_BIT      5
`define DMA_SHT_BIT      6
`define DMA_EM_BIT       7
`define DMA_PM_BIT       8

// ----------------------------------------------------------------
// Policy defaults
// ----------------------------------------------------------------
`define DMA_MAX_PKT_DEF  64

`endif

// >>> usb_dma_pkg.sv
// Types shared by the endpoint DMA packet policy
package usb_dma_pkg;

   typedef enum logic [4:0] {
      ST_IDLE     = 5'b0_0001,
      ST_LOAD     = 5'b0_0010,
      ST_ACTIVE   = 5'b0_0100,
      ST_WAIT_ZLP = 5'b0_1000,
      ST_SEND_ZLP = 5'b1_0000
   } dma_state_e;

   typedef logic [15:0] count_t;
   typedef logic [7:0]  pkt_len_t;

endpackage

// >>> usb_dma_chunk.sv
// Bytes the DMA may move into the IN packet under fill
`timescale 1ns/1ps
`include "usb_dma_regs.svh"
module usb_dma_chunk
   import usb_dma_pkg::*;
#(
   parameter int MAX_PKT = `DMA_MAX_PKT_DEF
) (
   input  wire count_t   rem_i,
   input  wire pkt_len_t fill_i,
   output pkt_len_t chunk_o
);

   wire pkt_len_t room = pkt_len_t'(MAX_PKT) - fill_i;
   wire           fits = rem_i < {8'h00, room};

   assign chunk_o = fits ? rem_i[7:0] : room;

endmodule // usb_dma_chunk

// >>> usb_dma_packet_policy.sv
// Endpoint DMA channel control register and packet policy engine
`timescale 1ns/1ps
`include "usb_dma_regs.svh"
module usb_dma_packet_policy
   import usb_dma_pkg::*;
#(
   parameter bit IS_IN   = 1'b0,
   parameter int MAX_PKT = `DMA_MAX_PKT_DEF
) (
   input  wire logic     CLK_I,
   input  wire logic     RST_I,
   input  wire logic     REG_WR_I,
   input  wire logic [15:0] REG_WDATA_I,
   output logic [15:0]   REG_RDATA_O,
   input  wire count_t   XFER_SIZE_I,
   input  wire logic     FRAME_I,
   input  wire logic     ISO_I,
   input  wire logic     PKT_SEEN_I,
   input  wire logic     OUT_PKT_VALID_I,
   input  wire pkt_len_t OUT_PKT_BYTES_I,
   input  wire logic     IN_BUF_FREE_I,
   output logic          IN_PKT_RELEASE_O,
   output pkt_len_t      IN_PKT_BYTES_O,
   output logic          CLR_BYTE_COUNT_O,
   output logic          OUT_DISCARD_O,
   output logic          SPLIT_VALID_O,
   output count_t        SPLIT_OFFSET_O,
   output logic          SWAP_O,
   output logic          BIG_ENDIAN_O,
   output logic          ACTIVE_O
);

   initial begin
      if (MAX_PKT < 1 || MAX_PKT > 255)
         $error("MAX_PKT must lie in 1..255");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   dma_state_e state_r, state_nxt;
   logic     stp_r, rld_r, ovf_r, end_r, cat_r, sht_r, em_r, pm_r;
   logic     sht_cap_r, cat_cap_r, end_cap_r;
   logic     seen_r, last_full_r, carry_pend_r;
   pkt_len_t carry_r, fill_r;
   count_t   rem_r;
   logic     release_r, clr_cnt_r, discard_r, split_r, swap_r;
   pkt_len_t rel_bytes_r;
   count_t   split_off_r;

   function automatic logic is_full(input pkt_len_t n);
      is_full = n == pkt_len_t'(MAX_PKT);
   endfunction

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire idle      = state_r == ST_IDLE;
   wire active    = state_r == ST_ACTIVE;
   wire wait_zlp  = state_r == ST_WAIT_ZLP;
   wire go_wr     = REG_WR_I && REG_WDATA_I[`DMA_GO_BIT]
                    && !REG_WDATA_I[`DMA_STP_BIT];
   wire start     = idle && go_wr;
   wire missed    = FRAME_I && ISO_I && !seen_r && !PKT_SEEN_I;
   wire pm_rise   = missed && !pm_r;
   wire halt      = em_r && pm_rise && !idle;
   wire miss_zero = missed && !em_r && !IS_IN;
   wire out_ev    = !IS_IN
                    && (OUT_PKT_VALID_I || miss_zero || carry_pend_r);
   wire pkt_len_t cnt = carry_pend_r ? carry_r
                      : (OUT_PKT_VALID_I ? OUT_PKT_BYTES_I : 8'h00);
   wire      over      = {8'h00, cnt} > rem_r;
   wire count_t rem_out = rem_r - {8'h00, cnt};
   wire      short_pkt = cnt < pkt_len_t'(MAX_PKT);

   pkt_len_t chunk;
   usb_dma_chunk #(.MAX_PKT(MAX_PKT)) u_chunk (
      .rem_i   (rem_r),
      .fill_i  (fill_r),
      .chunk_o (chunk)
   );
   wire pkt_len_t fill_new = pkt_len_t'(fill_r + chunk);
   wire count_t   rem_in   = rem_r - {8'h00, chunk};
   wire           in_step  = IS_IN && active && IN_BUF_FREE_I
                             && rem_r != 16'h0000;

   // ----------------------------------------------------------------
   // Transfer sequencing
   // ----------------------------------------------------------------
   logic finish, set_ovf, do_release, do_split, do_discard, do_clr;
   pkt_len_t rel_bytes;
   always_comb begin
      state_nxt  = state_r;
      finish     = 1'b0;
      set_ovf    = 1'b0;
      do_release = 1'b0;
      do_split   = 1'b0;
      do_discard = 1'b0;
      do_clr     = 1'b0;
      rel_bytes  = 8'h00;
      case (state_r)
         ST_IDLE: begin
            if (start)
               state_nxt = ST_LOAD;
         end
         ST_LOAD: begin
            state_nxt = ST_ACTIVE;
         end
         ST_ACTIVE: begin
            if (IS_IN) begin
               if (rem_r == 16'h0000) begin
                  if (last_full_r && sht_cap_r)
                     state_nxt = ST_SEND_ZLP;
                  else
                     finish = 1'b1;
               end else if (in_step) begin
                  if (is_full(fill_new)) begin
                     do_release = 1'b1;
                     rel_bytes  = fill_new;
                  end else if (rem_in == 16'h0000 && !cat_cap_r) begin
                     do_release = 1'b1;
                     rel_bytes  = fill_new;
                  end
               end
            end else if (out_ev) begin
               if (over && cat_cap_r) begin
                  do_split = 1'b1;
                  finish   = 1'b1;
               end else if (over) begin
                  set_ovf = 1'b1;
                  finish  = 1'b1;
               end else if (short_pkt) begin
                  finish = 1'b1;
               end else if (rem_out == 16'h0000) begin
                  if (sht_cap_r)
                     state_nxt = ST_WAIT_ZLP;
                  else
                     finish = 1'b1;
               end
            end
         end
         ST_WAIT_ZLP: begin
            if (out_ev) begin
               do_discard = cnt != 8'h00;
               finish     = 1'b1;
            end
         end
         ST_SEND_ZLP: begin
            if (IN_BUF_FREE_I) begin
               do_clr = 1'b1;
               finish = 1'b1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (finish)
         state_nxt = (rld_r && !stp_r) ? ST_LOAD : ST_IDLE;
      if (halt)
         state_nxt = ST_IDLE;
   end

   wire swap = finish && rld_r && !stp_r && !halt;
   wire load = state_r == ST_LOAD;

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         {em_r, sht_r, cat_r, end_r} <= 4'h0;
         {rld_r, stp_r} <= 2'b00;
      end else begin
         if (REG_WR_I) begin
            em_r  <= REG_WDATA_I[`DMA_EM_BIT];
            sht_r <= REG_WDATA_I[`DMA_SHT_BIT];
            cat_r <= REG_WDATA_I[`DMA_CAT_BIT];
            end_r <= REG_WDATA_I[`DMA_END_BIT];
            rld_r <= REG_WDATA_I[`DMA_RLD_BIT];
         end
         if (finish && stp_r)
            stp_r <= 1'b0;
         else if (REG_WR_I)
            stp_r <= REG_WDATA_I[`DMA_STP_BIT];
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I)
         ovf_r <= 1'b0;
      else if (set_ovf)
         ovf_r <= 1'b1;
      else if (REG_WR_I && REG_WDATA_I[`DMA_OVF_BIT])
         ovf_r <= 1'b0;
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         seen_r <= 1'b0;
         pm_r   <= 1'b0;
      end else if (FRAME_I) begin
         seen_r <= 1'b0;
         pm_r   <= missed;
      end else if (PKT_SEEN_I) begin
         seen_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Transfer state
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state_r <= ST_IDLE;
         {sht_cap_r, cat_cap_r, end_cap_r} <= 3'b000;
         rem_r <= 16'h0000;
         fill_r <= 8'h00;
         last_full_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (load) begin
            sht_cap_r <= sht_r;
            cat_cap_r <= cat_r;
            end_cap_r <= end_r;
            rem_r <= XFER_SIZE_I;
            last_full_r <= 1'b0;
         end else if (in_step) begin
            rem_r <= rem_in;
            last_full_r <= is_full(fill_new);
            fill_r <= (do_release || is_full(fill_new)) ? 8'h00
                      : fill_new;
         end else if (active && out_ev && !over) begin
            rem_r <= rem_out;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         carry_pend_r <= 1'b0;
         carry_r <= 8'h00;
      end else if (do_split) begin
         carry_pend_r <= 1'b1;
         carry_r <= cnt - rem_r[7:0];
      end else if (active && carry_pend_r) begin
         carry_pend_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Output strobes and data
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         {release_r, clr_cnt_r, discard_r, split_r, swap_r} <= 5'h00;
         rel_bytes_r <= 8'h00;
         split_off_r <= 16'h0000;
      end else begin
         release_r <= do_release;
         clr_cnt_r <= do_clr;
         discard_r <= do_discard;
         split_r   <= do_split;
         swap_r    <= swap;
         if (do_release)
            rel_bytes_r <= rel_bytes;
         if (do_split)
            split_off_r <= rem_r;
      end
   end

   assign IN_PKT_RELEASE_O = release_r;
   assign IN_PKT_BYTES_O   = rel_bytes_r;
   assign CLR_BYTE_COUNT_O = clr_cnt_r;
   assign OUT_DISCARD_O    = discard_r;
   assign SPLIT_VALID_O    = split_r;
   assign SPLIT_OFFSET_O   = split_off_r;
   assign SWAP_O           = swap_r;
   assign BIG_ENDIAN_O     = end_cap_r;
   assign ACTIVE_O         = !idle;

   // Reserved field reads zero
   assign REG_RDATA_O = {7'h00, pm_r, em_r, sht_r, cat_r, end_r,
                         ovf_r, rld_r, stp_r, !idle};

endmodule // usb_dma_packet_policy

// >>> usb_dma_policy_sva.sv
// Assertion checker for the endpoint DMA packet policy
`timescale 1ns/1ps
module usb_dma_policy_sva
   import usb_dma_pkg::*;
(
   input wire logic        CLK_I,
   input wire logic        RST_I,
   input wire logic        REG_WR_I,
   input wire logic        FRAME_I,
   input wire logic        OUT_PKT_VALID_I,
   input wire logic        ACTIVE_O,
   input wire logic        SPLIT_VALID_O,
   input wire logic        OUT_DISCARD_O,
   input wire logic        SWAP_O,
   input wire logic [15:0] REG_WDATA_I,
   input wire logic [15:0] REG_RDATA_O,
   input wire pkt_len_t    OUT_PKT_BYTES_I
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   sequence s_start;
      REG_WR_I && REG_WDATA_I[0] && !REG_WDATA_I[1] && !ACTIVE_O;
   endsequence
   sequence s_halt;
      ##[0:1] !ACTIVE_O;
   endsequence
   a_rsvd_zero: assert property (REG_RDATA_O[15:9] == 7'h00)
      else $error("reserved bits read nonzero");
   a_go_mirror: assert property (REG_RDATA_O[0] == ACTIVE_O)
      else $error("go bit differs from active");
   a_go_start: assert property (s_start |=> ACTIVE_O)
      else $error("start write did not launch");
   a_miss_halt: assert property ($rose(REG_RDATA_O[8]) &&
      REG_RDATA_O[7] && $past(ACTIVE_O) |-> s_halt)
      else $error("missed packet did not halt");
   a_pm_frame: assert property (!$stable(REG_RDATA_O[8])
      |-> $past(FRAME_I))
      else $error("missing flag moved off frame");
   a_ovf_cause: assert property ($rose(REG_RDATA_O[3]) |->
      $past(OUT_PKT_VALID_I))
      else $error("overflow without packet");
   a_ovf_clear: assert property (REG_WR_I && REG_WDATA_I[3] &&
      !OUT_PKT_VALID_I |=> !REG_RDATA_O[3])
      else $error("overflow not cleared");
   a_split_cause: assert property (SPLIT_VALID_O
      |-> $past(OUT_PKT_VALID_I))
      else $error("split without packet");
   a_discard_cause: assert property (OUT_DISCARD_O |->
      $past(OUT_PKT_VALID_I) && $past(OUT_PKT_BYTES_I) != 8'h00)
      else $error("discard without nonzero packet");
   a_swap_reload: assert property (SWAP_O |=> ACTIVE_O && !SWAP_O)
      else $error("swap not followed by reload");
endmodule // usb_dma_policy_sva
bind usb_dma_packet_policy usb_dma_policy_sva i_sva (
   .CLK_I(CLK_I), .RST_I(RST_I), .REG_WR_I(REG_WR_I), .FRAME_I(FRAME_I),
   .OUT_PKT_VALID_I(OUT_PKT_VALID_I), .ACTIVE_O(ACTIVE_O),
   .SPLIT_VALID_O(SPLIT_VALID_O), .OUT_DISCARD_O(OUT_DISCARD_O),
   .SWAP_O(SWAP_O), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
   .OUT_PKT_BYTES_I(OUT_PKT_BYTES_I));

// >>> usb_host_model.sv
// Behavioural USB host sending frames and OUT packets
`timescale 1ns/1ps
module usb_host_model
   import usb_dma_pkg::*;
(
   input  wire logic clk_i,
   output logic      frame_o,
   output logic      seen_o,
   output logic      valid_o,
   output pkt_len_t  bytes_o
);
   initial begin
      frame_o = 1'b0;
      seen_o = 1'b0;
      valid_o = 1'b0;
      bytes_o = 8'h00;
   end
   task automatic pkt(input pkt_len_t n);
      valid_o = 1'b1;
      seen_o = 1'b1;
      bytes_o = n;
      @(posedge clk_i);
      #1;
      valid_o = 1'b0;
      seen_o = 1'b0;
      bytes_o = ~n;
   endtask
   task automatic frame(input logic sent);
      frame_o = 1'b1;
      seen_o = sent;
      @(posedge clk_i);
      #1;
      frame_o = 1'b0;
      seen_o = 1'b0;
   endtask
endmodule // usb_host_model

// >>> tb_top.sv
// Self-checking bench for the OUT and IN endpoint packet policy
`timescale 1ns/1ps
module tb_top;
   import usb_dma_pkg::*;
   logic        CLK_I = 1'b0, RST_I = 1'b1, REG_WR_I = 1'b0, ISO_I = 1'b0;
   logic [15:0] REG_WDATA_I = 16'h0000, REG_RDATA_O;
   count_t      XFER_SIZE_I = 16'h0000, SPLIT_OFFSET_O;
   logic        FRAME_I, PKT_SEEN_I, OUT_PKT_VALID_I, ACTIVE_O;
   logic        SPLIT_VALID_O, OUT_DISCARD_O, SWAP_O;
   pkt_len_t    OUT_PKT_BYTES_I;
   logic [2:0]  seen = 3'b000;
   logic        wr_in_en = 1'b0, buf_free = 1'b0;
   logic        in_rel, in_clr, in_end, in_act;
   pkt_len_t    in_bytes;
   logic [1:0]  seen_in = 2'b00;
   int          fail_count = 0, samples_checked = 0, cyc = 0;
   initial forever #2.5 CLK_I = ~CLK_I;
   usb_dma_packet_policy #(.IS_IN(1'b0), .MAX_PKT(8)) i_dut (
      .CLK_I(CLK_I), .RST_I(RST_I), .REG_WR_I(REG_WR_I),
      .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
      .XFER_SIZE_I(XFER_SIZE_I), .FRAME_I(FRAME_I), .ISO_I(ISO_I),
      .PKT_SEEN_I(PKT_SEEN_I), .OUT_PKT_VALID_I(OUT_PKT_VALID_I),
      .OUT_PKT_BYTES_I(OUT_PKT_BYTES_I), .IN_BUF_FREE_I(buf_free),
      .IN_PKT_RELEASE_O(), .IN_PKT_BYTES_O(), .CLR_BYTE_COUNT_O(),
      .OUT_DISCARD_O(OUT_DISCARD_O), .SPLIT_VALID_O(SPLIT_VALID_O),
      .SPLIT_OFFSET_O(SPLIT_OFFSET_O), .SWAP_O(SWAP_O), .BIG_ENDIAN_O(),
      .ACTIVE_O(ACTIVE_O));
   usb_host_model i_host (.clk_i(CLK_I), .frame_o(FRAME_I),
      .seen_o(PKT_SEEN_I), .valid_o(OUT_PKT_VALID_I),
      .bytes_o(OUT_PKT_BYTES_I));
   usb_dma_packet_policy #(.IS_IN(1'b1), .MAX_PKT(8)) i_dut_in (
      .CLK_I(CLK_I), .RST_I(RST_I), .REG_WR_I(wr_in_en),
      .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(),
      .XFER_SIZE_I(XFER_SIZE_I), .FRAME_I(FRAME_I), .ISO_I(ISO_I),
      .PKT_SEEN_I(PKT_SEEN_I), .OUT_PKT_VALID_I(1'b0),
      .OUT_PKT_BYTES_I(8'h00), .IN_BUF_FREE_I(buf_free),
      .IN_PKT_RELEASE_O(in_rel), .IN_PKT_BYTES_O(in_bytes),
      .CLR_BYTE_COUNT_O(in_clr), .OUT_DISCARD_O(), .SPLIT_VALID_O(),
      .SPLIT_OFFSET_O(), .SWAP_O(), .BIG_ENDIAN_O(in_end),
      .ACTIVE_O(in_act));
   always @(posedge CLK_I) begin
      cyc++;
      seen <= seen | {SPLIT_VALID_O, OUT_DISCARD_O, SWAP_O};
      seen_in <= seen_in | {in_clr, in_rel};
      if (cyc == 3000) begin
         fail_count++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic tick(input int n = 1);
      repeat (n) @(posedge CLK_I);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] d);
      REG_WDATA_I = d;
      REG_WR_I = 1'b1;
      tick();
      REG_WR_I = 1'b0;
   endtask
   task automatic go(input logic [15:0] c, input count_t sz);
      XFER_SIZE_I = sz;
      seen = 3'b000;
      wr(c | 16'h0001);
      tick(2);
   endtask
   task automatic in_go(input logic [15:0] c, input count_t sz);
      XFER_SIZE_I = sz;
      seen_in = 2'b00;
      REG_WDATA_I = c;
      wr_in_en = 1'b1;
      tick();
      wr_in_en = 1'b0;
      tick(8);
   endtask
   task automatic t_reset();
      chk("ctl", 16'h0000, REG_RDATA_O);
      wr(16'h0003);
      tick();
      chk("active", 16'h0000, 16'(ACTIVE_O));
      wr(16'h0000);
      tick();
   endtask
   task automatic t_full_end();
      go(16'h0000, 16'h0008);
      i_host.pkt(8'h08);
      tick(3);
      chk("active", 16'h0000, 16'(ACTIVE_O));
   endtask
   task automatic t_zlp_wait();
      go(16'h0040, 16'h0008);
      wr(16'h0000);
      i_host.pkt(8'h08);
      tick(3);
      chk("active", 16'h0001, 16'(ACTIVE_O));
      i_host.pkt(8'h03);
      tick(3);
      chk("discard", 16'h0001, 16'(seen[1]));
      chk("active", 16'h0000, 16'(ACTIVE_O));
   endtask
   task automatic t_overflow();
      go(16'h0000, 16'h0004);
      i_host.pkt(8'h06);
      tick(3);
      chk("ctl", 16'h0008, REG_RDATA_O);
      wr(16'h0008);
      tick();
      chk("ctl", 16'h0000, REG_RDATA_O);
   endtask
   task automatic t_join();
      go(16'h0020, 16'h0004);
      i_host.pkt(8'h06);
      tick(3);
      chk("split", 16'h0001, 16'(seen[2]));
      chk("offset", 16'h0004, SPLIT_OFFSET_O);
      chk("ctl", 16'h0020, REG_RDATA_O);
      go(16'h0000, 16'h0008);
      tick(3);
      chk("active", 16'h0000, 16'(ACTIVE_O));
   endtask
   task automatic t_reload();
      go(16'h0004, 16'h0004);
      i_host.pkt(8'h02);
      tick(3);
      chk("swap", 16'h0001, 16'(seen[0]));
      chk("active", 16'h0001, 16'(ACTIVE_O));
      wr(16'h0000);
      i_host.pkt(8'h02);
      tick(3);
      chk("active", 16'h0000, 16'(ACTIVE_O));
   endtask
   task automatic t_missing();
      ISO_I = 1'b1;
      go(16'h0080, 16'h0020);
      i_host.frame(1'b1);
      i_host.frame(1'b0);
      tick(3);
      chk("ctl", 16'h0180, REG_RDATA_O);
      i_host.frame(1'b1);
      tick(2);
      chk("ctl", 16'h0080, REG_RDATA_O);
      go(16'h0000, 16'h0020);
      i_host.frame(1'b0);
      tick(3);
      chk("active", 16'h0000, 16'(ACTIVE_O));
      ISO_I = 1'b0;
   endtask
   task automatic t_in();
      buf_free = 1'b1;
      in_go(16'h0051, 16'h0008);
      chk("in_seen", 16'h0003, 16'(seen_in));
      chk("in_bytes", 16'h0008, 16'(in_bytes));
      chk("endian", 16'h0001, 16'(in_end));
      chk("in_active", 16'h0000, 16'(in_act));
      in_go(16'h0001, 16'h0008);
      chk("in_seen", 16'h0001, 16'(seen_in));
      in_go(16'h0001, 16'h0003);
      chk("in_bytes", 16'h0003, 16'(in_bytes));
      in_go(16'h0021, 16'h0003);
      chk("in_seen", 16'h0000, 16'(seen_in));
      in_go(16'h0001, 16'h0005);
      chk("in_bytes", 16'h0008, 16'(in_bytes));
      chk("endian", 16'h0000, 16'(in_end));
      buf_free = 1'b0;
   endtask
   initial begin
      tick(6);
      RST_I = 1'b0;
      tick();
      t_reset();
      t_full_end();
      t_zlp_wait();
      t_overflow();
      t_join();
      t_reload();
      t_missing();
      t_in();
      close_out();
   end
endmodule // tb_top
